/* hw/fcsm_fault_manager.v */
// Purpose: Moves the device between active, safe and latched-off modes
//          as the fault monitors report, and keeps the fault count.
// Assumes: Monitor flags are asynchronous levels, high while a fault holds.
// Notes:   Safe is left once every monitor flag has been low for a cycle.
`timescale 1ns/1ps
`default_nettype none
`include "fcsm_regs.vh"

module fcsm_fault_manager #(
  parameter [`FCSM_TMR_W-1:0] LONG_CYC    = `FCSM_LONG_CYC,
  parameter [`FCSM_TMR_W-1:0] SHORT_CYC   = `FCSM_SHORT_CYC,
  parameter [`FCSM_FC_W-1:0]  FAULT_LIMIT = `FCSM_FAULT_LIMIT
) (
  // Clock and reset.
  input  wire                  ref_clk,
  input  wire                  rst,
  // Fault flags from the analog monitors.
  input  wire                  battery_supply_uv,
  input  wire                  overtemp,
  input  wire                  charge_pump_supply_uv,
  // Mode and fault bookkeeping.
  output reg  [1:0]            mode_reg,
  output reg  [`FCSM_FC_W-1:0] fault_counter_reg,
  output reg                   refresh_long_reg,
  output reg                   hist_ot_reg,
  output reg                   hist_cp_reg,
  // Refresh timer status.
  output reg                   refresh_running_reg
);

  // Synchroniser stages and edge history for the three flags.
  reg  [2:0] sync1_reg;
  reg  [2:0] sync2_reg;
  reg  [2:0] prev_reg;
  wire [2:0] rise;
  wire       ev_vs;
  wire       ev_ot;
  wire       ev_cp;
  wire       ev_count;
  wire       any_level;

  // Internal state.
  reg  [1:0]            cause_reg;
  reg                   arm_reg;
  reg                   latch_pend_reg;
  reg  [1:0]            mode_next;
  reg  [1:0]            cause_next;
  reg  [`FCSM_FC_W-1:0] fc_next;
  reg                   long_next;
  reg                   hist_ot_next;
  reg                   hist_cp_next;
  reg                   arm_next;
  reg                   pend_next;
  reg                   tmr_start;
  reg                   tmr_stop;
  wire                  tmr_running;
  wire                  tmr_expired;
  wire [`FCSM_FC_W-1:0] fc_inc;

  // Adds one to the count but never wraps past the latch value.
  function [`FCSM_FC_W-1:0] fc_plus;
    input [`FCSM_FC_W-1:0] fc;
    begin
      if (fc >= FAULT_LIMIT)
        fc_plus = FAULT_LIMIT;
      else
        fc_plus = fc + 1'b1;
    end
  endfunction

  // Flags are pins from the analog side, so they pass two flip-flops.
  always @(posedge ref_clk)
  begin
    if (rst)
    begin
      sync1_reg <= 3'h0;
      sync2_reg <= 3'h0;
      prev_reg  <= 3'h0;
    end
    else
    begin
      sync1_reg <= {charge_pump_supply_uv, overtemp, battery_supply_uv};
      sync2_reg <= sync1_reg;
      prev_reg  <= sync2_reg;
    end
  end

  // A fault is counted once per onset, not for every cycle it holds.
  assign rise      = sync2_reg & ~prev_reg;
  assign ev_vs     = rise[`FCSM_BIT_VS];
  assign ev_ot     = rise[`FCSM_BIT_OT];
  assign ev_cp     = rise[`FCSM_BIT_CP];
  assign ev_count  = ev_ot | ev_cp;
  assign any_level = |sync2_reg;
  assign fc_inc    = fc_plus(fault_counter_reg);

  // Next-state decision. Simultaneous onsets count as one fault, and
  // overtemperature takes precedence for cause and threshold.
  always @*
  begin
    mode_next    = mode_reg;
    cause_next   = cause_reg;
    fc_next      = fault_counter_reg;
    long_next    = refresh_long_reg;
    hist_ot_next = hist_ot_reg;
    hist_cp_next = hist_cp_reg;
    arm_next     = arm_reg;
    pend_next    = 1'b0;
    tmr_start    = 1'b0;
    tmr_stop     = 1'b0;
    case (mode_reg)
      `FCSM_ST_ACTIVE:
      begin
        if (ev_count)
        begin
          mode_next    = `FCSM_ST_SAFE;
          cause_next   = ev_ot ? `FCSM_CAUSE_OT : `FCSM_CAUSE_CP;
          fc_next      = fc_inc; // RQ2 RQ3
          hist_ot_next = hist_ot_reg | ev_ot;
          hist_cp_next = hist_cp_reg | ev_cp;
          long_next    = hist_ot_reg | ev_ot; // RQ2 RQ5
          arm_next     = 1'b1; // RQ2 RQ4
          pend_next    = (fc_inc >= FAULT_LIMIT); // RQ3
          tmr_stop     = 1'b1;
        end
        else if (ev_vs)
        begin
          mode_next  = `FCSM_ST_SAFE;
          cause_next = `FCSM_CAUSE_VS;
          if (hist_ot_reg | hist_cp_reg)
          begin
            long_next = hist_ot_reg; // RQ6
            arm_next  = 1'b1; // RQ6
          end
          else
          begin
            long_next = `FCSM_RST_LONG; // RQ1
            arm_next  = 1'b0; // RQ1
          end
          tmr_stop = 1'b1;
        end
        else if (tmr_expired)
        begin
          // The quiet period has elapsed, so the history is forgiven.
          fc_next      = `FCSM_RST_FC; // RQ11
          hist_ot_next = 1'b0; // RQ11
          hist_cp_next = 1'b0; // RQ11
          long_next    = `FCSM_RST_LONG;
          arm_next     = 1'b0;
          tmr_stop     = 1'b1; // RQ11
        end
      end
      `FCSM_ST_SAFE:
      begin
        if (latch_pend_reg)
          mode_next = `FCSM_ST_LATCH; // RQ3
        else if (cause_reg == `FCSM_CAUSE_VS)
        begin
          if (ev_count)
          begin
            fc_next      = fc_inc; // RQ7
            cause_next   = ev_ot ? `FCSM_CAUSE_OT : `FCSM_CAUSE_CP;
            hist_ot_next = hist_ot_reg | ev_ot;
            hist_cp_next = hist_cp_reg | ev_cp;
            long_next    = hist_ot_reg | ev_ot; // RQ7 RQ5
            arm_next     = 1'b1;
            if (fc_inc >= FAULT_LIMIT)
              mode_next = `FCSM_ST_LATCH; // RQ7
          end
          else if (!any_level)
            mode_next = `FCSM_ST_ACTIVE;
        end
        else
        begin
          // Only the other counted fault matters here; a repeat of the
          // cause and a supply dip leave count and threshold alone.
          if ((cause_reg == `FCSM_CAUSE_OT && ev_cp) ||
              (cause_reg == `FCSM_CAUSE_CP && ev_ot))
          begin
            hist_ot_next = 1'b1; // RQ8
            hist_cp_next = 1'b1;
            long_next    = 1'b1; // RQ8
            arm_next     = 1'b1; // RQ8
          end
          else if (!any_level && !ev_vs)
            mode_next = `FCSM_ST_ACTIVE; // RQ9
        end
        // Returning to active starts the timer only if it was armed.
        if (mode_next == `FCSM_ST_ACTIVE && arm_reg)
          tmr_start = 1'b1; // RQ2 RQ4 RQ6
      end
      `FCSM_ST_LATCH:
      begin
        mode_next = `FCSM_ST_LATCH; // RQ10
        tmr_stop  = 1'b1; // RQ10
      end
      default:
      begin
        mode_next = `FCSM_ST_LATCH;
        tmr_stop  = 1'b1;
      end
    endcase
  end

  // State registers; only reset releases the latched mode.
  always @(posedge ref_clk)
  begin
    if (rst)
    begin
      mode_reg            <= `FCSM_ST_ACTIVE; // RQ10
      cause_reg           <= `FCSM_CAUSE_VS;
      fault_counter_reg   <= `FCSM_RST_FC;
      refresh_long_reg    <= `FCSM_RST_LONG;
      hist_ot_reg         <= 1'b0;
      hist_cp_reg         <= 1'b0;
      arm_reg             <= 1'b0;
      latch_pend_reg      <= 1'b0;
      refresh_running_reg <= 1'b0;
    end
    else
    begin
      mode_reg            <= mode_next;
      cause_reg           <= cause_next;
      fault_counter_reg   <= fc_next;
      refresh_long_reg    <= long_next;
      hist_ot_reg         <= hist_ot_next;
      hist_cp_reg         <= hist_cp_next;
      arm_reg             <= arm_next;
      latch_pend_reg      <= pend_next;
      refresh_running_reg <= tmr_running;
    end
  end

  // The timer sees the threshold already chosen for this quiet period.
  fcsm_refresh_timer #(
    .LONG_CYC  (LONG_CYC),
    .SHORT_CYC (SHORT_CYC)
  ) u_timer (
    .ref_clk     (ref_clk),
    .rst         (rst),
    .start       (tmr_start),
    .stop        (tmr_stop),
    .thr_long    (refresh_long_reg),
    .running_reg (tmr_running),
    .expired_reg (tmr_expired)
  );

endmodule // fcsm_fault_manager
`default_nettype wire

/* hw/fcsm_refresh_timer.v */
// Purpose: Refresh timer that counts up to a selected threshold.
// Assumes: Start is a single-cycle pulse on ref_clk; stop is held high while latched.
// Notes:   Start wins over stop; expiry stops the timer by itself.
`timescale 1ns/1ps
`default_nettype none
`include "fcsm_regs.vh"

module fcsm_refresh_timer #(
  parameter [`FCSM_TMR_W-1:0] LONG_CYC  = `FCSM_LONG_CYC,
  parameter [`FCSM_TMR_W-1:0] SHORT_CYC = `FCSM_SHORT_CYC
) (
  // Clock and reset.
  input  wire                   ref_clk,
  input  wire                   rst,
  // Control from the state manager.
  input  wire                   start,
  input  wire                   stop,
  input  wire                   thr_long,
  // Status back to the state manager.
  output reg                    running_reg,
  output reg                    expired_reg
);

  reg  [`FCSM_TMR_W-1:0] count_reg;
  wire [`FCSM_TMR_W-1:0] limit;

  // The last count before the threshold is reached.
  assign limit = (thr_long ? LONG_CYC : SHORT_CYC) - 1'b1;

  // Counting restarts from zero on every start pulse.
  always @(posedge ref_clk)
  begin
    if (rst)
    begin
      count_reg   <= {`FCSM_TMR_W{1'b0}};
      running_reg <= 1'b0;
      expired_reg <= 1'b0;
    end
    else
    begin
      expired_reg <= 1'b0;
      if (start)
      begin
        count_reg   <= {`FCSM_TMR_W{1'b0}}; // RQ4
        running_reg <= 1'b1;
      end
      else if (stop)
        running_reg <= 1'b0;
      else if (running_reg)
      begin
        if (count_reg >= limit)
        begin
          running_reg <= 1'b0;
          expired_reg <= 1'b1;
        end
        else
          count_reg <= count_reg + 1'b1;
      end
    end
  end

endmodule // fcsm_refresh_timer
`default_nettype wire

/* hw/fcsm_regs.vh */
// Purpose: Constants for the fault counter state manager.
// Assumes: A 40 MHz reference clock and a synchronous active-high reset.
// Notes:   Definitions only; included by bare name from the design files.
// Behaviour
// [RQ1] First supply dip: safe, count kept, timer idle
// [RQ2] First hot or pump fault: count, arm timer
// [RQ3] Repeat fault counts; fourth goes safe, then latch
// [RQ4] Repeat counted fault restarts timer from zero
// [RQ5] Any overtemperature in history selects long threshold
// [RQ6] Later supply dip: safe, count kept, restart
// [RQ7] Counted fault during supply safe: count or latch
// [RQ8] Second safe cause not recounted, long threshold
// [RQ9] Supply dip during safe keeps count, threshold
// [RQ10] Latched state is left only by reset
// [RQ11] Timer expiry in active clears count, history
`ifndef FCSM_REGS_VH
`define FCSM_REGS_VH

// Reference clock rate in hertz.
`define FCSM_CLK_HZ         40000000
// Refresh thresholds as times.
`define FCSM_REFRESH_LONG_S  30
`define FCSM_REFRESH_SHORT_MS 100
// Refresh thresholds in reference clock cycles.
`define FCSM_LONG_CYC  (`FCSM_REFRESH_LONG_S * `FCSM_CLK_HZ)
`define FCSM_SHORT_CYC (`FCSM_REFRESH_SHORT_MS * (`FCSM_CLK_HZ / 1000))
// Width of the refresh timer count.
`define FCSM_TMR_W     31
// Fault count that latches the device off.
`define FCSM_FAULT_LIMIT 4
// Width of the fault counter.
`define FCSM_FC_W      3
// Mode encodings.
`define FCSM_ST_ACTIVE 2'h0
`define FCSM_ST_SAFE   2'h1
`define FCSM_ST_LATCH  2'h2
// Safe cause encodings.
`define FCSM_CAUSE_VS  2'h0
`define FCSM_CAUSE_OT  2'h1
`define FCSM_CAUSE_CP  2'h2
// Fault input bit positions.
`define FCSM_BIT_VS    0
`define FCSM_BIT_OT    1
`define FCSM_BIT_CP    2
// Reset values.
`define FCSM_RST_FC    3'h0
`define FCSM_RST_LONG  1'b1

`endif

/* tb/fcsm_fault_manager_bench.sv */
// Purpose: Random fault sequences checked against a reference model.
// Assumes: Shortened thresholds; one flag rises per onset step, returns drop all.
// Notes:   Expiry steps are 75 cycles, so thresholds stay unambiguous.
`timescale 1ns/1ps
`default_nettype none
`include "fcsm_regs.vh"
`define CHK(got, exp) begin check_count++; if ((got) !== (exp)) begin \
  errors++; $display("CHECK FAILED at %0t: output mismatch", $time); end end

module fcsm_fault_manager_bench;
  localparam [`FCSM_TMR_W-1:0] LONG_T  = 31'h000000C8;
  localparam [`FCSM_TMR_W-1:0] SHORT_T = 31'h0000003C;
  logic                  ref_clk;
  logic                  rst;
  logic [2:0]            want;
  logic                  slow;
  wire logic             vs_f;
  wire logic             ot_f;
  wire logic             cp_f;
  wire logic [1:0]       mode;
  wire logic [2:0]       fc;
  wire logic             lng;
  wire logic             hot;
  wire logic             hcp;
  wire logic             run;
  int errors, check_count, cycles, k, m_mode, m_fc, m_long, m_hot, m_hcp;
  int m_cause, m_exp;

  fcsm_monitor_model mon (.ref_clk(ref_clk), .want(want), .slow(slow),
    .battery_supply_uv(vs_f), .overtemp(ot_f), .charge_pump_supply_uv(cp_f));
  fcsm_fault_manager #(.LONG_CYC(LONG_T), .SHORT_CYC(SHORT_T),
    .FAULT_LIMIT(3'h4)) dut (.ref_clk(ref_clk), .rst(rst),
    .battery_supply_uv(vs_f), .overtemp(ot_f), .charge_pump_supply_uv(cp_f),
    .mode_reg(mode), .fault_counter_reg(fc), .refresh_long_reg(lng),
    .hist_ot_reg(hot), .hist_cp_reg(hcp), .refresh_running_reg(run));

  // Free-running 40 MHz clock.
  always #12.5 ref_clk = ~ref_clk;

  // Cut a hang short well above the expected run length.
  always @(posedge ref_clk)
  begin
    cycles++;
    if (cycles == 60000)
    begin
      errors++;
      results;
    end
  end

  task results;
    if (errors == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task reset_all;
    rst = 1'b1;
    want = 3'h0;
    repeat (20) @(negedge ref_clk);
    rst = 1'b0;
    {m_mode, m_fc, m_hot, m_hcp, m_exp} = 0;
    m_long = 1;
    repeat (2) @(negedge ref_clk);
  endtask

  // Counted fault: a fourth count latches the device off.
  task count_fault(input int f);
    m_fc++;
    if (f == 1) m_hot = 1;
    else m_hcp = 1;
    m_long = m_hot;
    if (m_fc >= 4) m_mode = 2;
  endtask

  // Reference reaction to a new flag onset.
  task onset(input int f);
    if (m_mode == 0)
    begin
      m_mode = 1;
      m_cause = f;
      if (f != 0) count_fault(f);
    end
    else if (m_mode == 1 && f != 0 && f != m_cause)
    begin
      if (m_cause == 0) count_fault(f);
      else
      begin
        // Each field is a full int, so set them one by one.
        m_hot = 1;
        m_hcp = 1;
        m_long = 1;
      end
      m_cause = f;
    end
  endtask

  task check_all;
    `CHK(mode, 2'(m_mode))
    `CHK(fc, 3'(m_fc))
    `CHK(lng, 1'(m_long))
    `CHK(hot, 1'(m_hot))
    `CHK(hcp, 1'(m_hcp))
    `CHK(run, 1'(m_mode == 0 && (m_hot || m_hcp)))
  endtask

  // Random walk over onsets, returns, expiries and resets.
  initial
  begin
    {ref_clk, rst, slow, want, errors, check_count, cycles} = 0;
    void'($urandom(34));
    reset_all;
    repeat (300)
    begin
      k = $urandom_range(3, 0);
      slow = 1'($urandom_range(1, 0));
      if (k < 3)
      begin
        if (!want[k]) onset(k);
        want[k] = 1'b1;
        repeat (12) @(negedge ref_clk);
      end
      else if (m_mode == 2) reset_all;
      else if (m_mode == 1)
      begin
        want = 3'h0;
        {m_mode, m_exp} = 0;
        repeat (12) @(negedge ref_clk);
      end
      else
      begin
        m_exp++;
        repeat (75) @(negedge ref_clk);
        if ((m_hot || m_hcp) && m_exp * 75 >=
            int'(m_long ? LONG_T : SHORT_T) + 15)
        begin
          {m_fc, m_hot, m_hcp} = 0;
          m_long = 1;
        end
      end
      check_all;
    end
    results;
  end
endmodule // fcsm_fault_manager_bench
`default_nettype wire

/* tb/fcsm_fault_manager_props.sv */
// Purpose: Concurrent checks on the fault manager outputs.
// Assumes: Bound into fcsm_fault_manager; reset is synchronous.
// Notes:   Windows leave room for the flag synchronisers.
`timescale 1ns/1ps
`default_nettype none
`include "fcsm_regs.vh"

module fcsm_fault_manager_props #(
  parameter [`FCSM_FC_W-1:0] FAULT_LIMIT = `FCSM_FAULT_LIMIT
) (
  // Clock and reset.
  input wire logic                  ref_clk,
  input wire logic                  rst,
  // Monitor flags.
  input wire logic                  battery_supply_uv,
  input wire logic                  overtemp,
  input wire logic                  charge_pump_supply_uv,
  // Observed state.
  input wire logic [1:0]            mode_reg,
  input wire logic [`FCSM_FC_W-1:0] fault_counter_reg,
  input wire logic                  refresh_long_reg,
  input wire logic                  hist_ot_reg,
  input wire logic                  hist_cp_reg,
  input wire logic                  refresh_running_reg
);
  // All checks share the one clock and its reset.
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  a_latch_is_final: assert property (mode_reg == `FCSM_ST_LATCH |=>
    mode_reg == `FCSM_ST_LATCH) else $error("latch left");
  a_count_steps_one: assert property ($changed(fault_counter_reg) |->
    fault_counter_reg == $past(fault_counter_reg) + 1'b1 ||
    (fault_counter_reg == 0 && mode_reg == `FCSM_ST_ACTIVE))
    else $error("count jumped");
  a_count_capped: assert property (fault_counter_reg <= FAULT_LIMIT)
    else $error("count over limit");
  a_limit_then_latch: assert property (mode_reg == `FCSM_ST_SAFE &&
    fault_counter_reg == FAULT_LIMIT |=> mode_reg == `FCSM_ST_LATCH)
    else $error("no latch at limit");
  a_latch_needs_limit: assert property (mode_reg != `FCSM_ST_LATCH ##1
    mode_reg == `FCSM_ST_LATCH |-> fault_counter_reg == FAULT_LIMIT)
    else $error("latched below limit");
  a_count_not_active: assert property (fault_counter_reg ==
    $past(fault_counter_reg) + 1'b1 |-> mode_reg != `FCSM_ST_ACTIVE)
    else $error("count rose in active");
  a_timer_stopped: assert property ((mode_reg != `FCSM_ST_ACTIVE) [*4]
    |-> !refresh_running_reg) else $error("timer runs in safe");
  a_expiry_clears: assert property ($fell(refresh_running_reg) &&
    mode_reg == `FCSM_ST_ACTIVE |-> ##[0:2] fault_counter_reg == 0)
    else $error("expiry left count");
  a_hot_means_long: assert property (hist_ot_reg &&
    $stable(hist_ot_reg) |-> refresh_long_reg)
    else $error("short threshold after hot");
  a_short_needs_cp: assert property (!refresh_long_reg &&
    $stable(refresh_long_reg) |-> hist_cp_reg)
    else $error("short threshold without pump");
  // Leaving safe needs every flag low where the synchroniser took it in.
  a_exit_when_quiet: assert property (mode_reg == `FCSM_ST_SAFE ##1
    mode_reg == `FCSM_ST_ACTIVE |-> !$past(battery_supply_uv, 3) &&
    !$past(overtemp, 3) && !$past(charge_pump_supply_uv, 3))
    else $error("safe left with a flag high");
endmodule // fcsm_fault_manager_props

bind fcsm_fault_manager fcsm_fault_manager_props #(
  .FAULT_LIMIT(FAULT_LIMIT)) u_props (.ref_clk(ref_clk), .rst(rst),
  .battery_supply_uv(battery_supply_uv), .overtemp(overtemp),
  .charge_pump_supply_uv(charge_pump_supply_uv), .mode_reg(mode_reg),
  .fault_counter_reg(fault_counter_reg), .hist_ot_reg(hist_ot_reg),
  .refresh_long_reg(refresh_long_reg), .hist_cp_reg(hist_cp_reg),
  .refresh_running_reg(refresh_running_reg));
`default_nettype wire

/* tb/fcsm_monitor_model.sv */
// Purpose: Stand-in for the three analog fault monitors.
// Assumes: The bench sets the wanted fault levels.
// Notes:   Slow mode delays flags two cycles, as a filtered comparator.
`timescale 1ns/1ps
`default_nettype none

module fcsm_monitor_model (
  // Clock.
  input  wire logic       ref_clk,
  // Wanted levels and response speed.
  input  wire logic [2:0] want,
  input  wire logic       slow,
  // Flags toward the fault manager.
  output wire logic       battery_supply_uv,
  output wire logic       overtemp,
  output wire logic       charge_pump_supply_uv
);
  logic [2:0] lag1_reg;
  logic [2:0] lag2_reg;

  // Two-stage lag for the slow response.
  always @(posedge ref_clk)
  begin
    lag1_reg <= want;
    lag2_reg <= lag1_reg;
  end

  // Bit 0 supply, bit 1 temperature, bit 2 pump.
  assign {charge_pump_supply_uv, overtemp, battery_supply_uv} =
    slow ? lag2_reg : want;
endmodule // fcsm_monitor_model
`default_nettype wire
